// ### inc/eeprom_pkg.sv
// What this block does
// RL1: Reads behave the same whatever write_inhibit_pin shows
// RL2: Unprogrammed locations read back as FF
// RL3: Address counter advances after every byte output
// RL4: Select with read bit returns current-address byte
// RL5: Single read ends with no acknowledge, STOP
// RL6: Random read: dummy write, repeated START, read
// RL7: Both select bytes share upper seven bits
// RL8: Sequential read follows either read kind
// RL9: Acknowledged byte is followed by next address
// RL10: Stream ends with withheld acknowledge, then STOP
// RL11: Counter wraps from top to bottom address
// RL12: No acknowledge in ninth slot returns standby
// RL13: Select is not acknowledged while programming
// RL14: Counter holds eleven bits, 2048 bytes
package eeprom_pkg;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned MEM_DEPTH  = 2048;
  localparam int unsigned PAGE_W     = 4;
  localparam logic [7:0]  ERASED     = 8'hFF;
  localparam logic [3:0]  SEL_CODE   = 4'hA;
  localparam logic [3:0]  BIT_LAST   = 4'h8;
  localparam int unsigned CLK_NS     = 8;
  localparam int unsigned T_SCL_NS   = 2500;
  localparam int unsigned T_WRITE_NS = 5000000;
  localparam int unsigned QUARTER_CYCLES = (T_SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_WRITE_CYCLES = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### inc/eeprom_link.sv
`timescale 1ns/1ps
interface eeprom_link;
  logic scl_line;
  logic sda_line;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;

  // Open-drain wired-AND with pull-ups: a driver only ever pulls low
  assign scl_line = ~(m_scl_oe & ~m_scl_out);
  assign sda_line = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport host (
    input  scl_line,
    input  sda_line,
    output m_scl_out,
    output m_scl_oe,
    output m_sda_out,
    output m_sda_oe
  );

  modport eeprom (
    input  scl_line,
    input  sda_line,
    output s_sda_out,
    output s_sda_oe
  );
endinterface

// ### rtl/byte_skid2.sv
`timescale 1ns/1ps
module byte_skid2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         v0_reg;
  logic         v0_next;
  logic         v1_reg;
  logic         v1_next;
  logic [W-1:0] d0_reg;
  logic [W-1:0] d0_next;
  logic [W-1:0] d1_reg;
  logic [W-1:0] d1_next;
  logic         push;
  logic         pop;

  assign in_ready  = ~v1_reg;
  assign out_valid = v0_reg;
  assign out_data  = d0_reg;
  assign push      = in_valid & ~v1_reg;
  assign pop       = v0_reg & out_ready;

  always_comb begin
    v0_next = v0_reg;
    v1_next = v1_reg;
    d0_next = d0_reg;
    d1_next = d1_reg;
    if (pop) begin
      d0_next = v1_reg ? d1_reg : in_data;
      v0_next = v1_reg | push;
      v1_next = 1'b0;
    end else if (push) begin
      if (v0_reg) begin
        d1_next = in_data;
        v1_next = 1'b1;
      end else begin
        d0_next = in_data;
        v0_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
      d0_reg <= '0;
      d1_reg <= '0;
    end else begin
      v0_reg <= v0_next;
      v1_reg <= v1_next;
      d0_reg <= d0_next;
      d1_reg <= d1_next;
    end
  end
endmodule

// ### rtl/eeprom_read_end.sv
`timescale 1ns/1ps
module eeprom_read_end import eeprom_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = T_WRITE_CYCLES,
  parameter logic [3:0]  SELECT_CODE  = SEL_CODE
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  eeprom_link.eeprom             link,
  input  wire logic              write_inhibit_pin,
  output logic                   busy,
  output logic [ADDR_W-1:0]      byte_addr
);
  localparam int unsigned BW = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SEL     = 4'h1,
    ST_SEL_ACK = 4'h2,
    ST_ADR     = 4'h3,
    ST_ADR_ACK = 4'h4,
    ST_WR      = 4'h5,
    ST_WR_ACK  = 4'h6,
    ST_RD      = 4'h7,
    ST_RD_ACK  = 4'h8
  } state_type;

  function automatic logic [ADDR_W-1:0] bump(input logic [ADDR_W-1:0] a, input logic page);
    logic [ADDR_W-1:0] n;
    n = a + 1'b1;
    if (page) begin
      n = {a[ADDR_W-1:PAGE_W], n[PAGE_W-1:0]};
    end
    return n;
  endfunction

  logic [7:0]        mem [MEM_DEPTH];
  logic              scl_s1_reg;
  logic              scl_s2_reg;
  logic              scl_d_reg;
  logic              sda_s1_reg;
  logic              sda_s2_reg;
  logic              sda_d_reg;
  logic              wp_s1_reg;
  logic              wp_s2_reg;
  state_type         state_reg;
  state_type         state_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  logic [7:0]        shift_reg;
  logic [7:0]        shift_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [2:0]        hi_reg;
  logic [2:0]        hi_next;
  logic              rw_reg;
  logic              rw_next;
  logic              oe_reg;
  logic              oe_next;
  logic              ack_reg;
  logic              ack_next;
  logic              wrote_reg;
  logic              wrote_next;
  logic [BW-1:0]     bcnt_reg;
  logic [BW-1:0]     bcnt_next;
  logic              busy_reg;
  logic              out_reg;
  logic              mem_we;
  logic              load;
  logic [7:0]        rd_byte;
  logic              start_det;
  logic              stop_det;
  logic              scl_rise;
  logic              scl_fall;

  assign link.s_sda_oe  = oe_reg;
  assign link.s_sda_out = out_reg;
  assign busy           = busy_reg;
  assign byte_addr      = addr_reg;

  assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  assign scl_rise  = scl_s2_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_s2_reg & scl_d_reg;
  assign rd_byte   = mem[addr_reg];

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    addr_next  = addr_reg;
    hi_next    = hi_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    ack_next   = ack_reg;
    wrote_next = wrote_reg;
    bcnt_next  = bcnt_reg;
    mem_we     = 1'b0;
    load       = 1'b0;
    if (bcnt_reg != '0) begin
      bcnt_next = bcnt_reg - 1'b1;
    end
    if (start_det) begin
      state_next = ST_SEL;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      if (wrote_reg) begin
        // Programming starts only on STOP after accepted data
        bcnt_next  = BW'(WRITE_CYCLES);
        wrote_next = 1'b0;
      end
    end else if (scl_rise) begin
      if (state_reg == ST_SEL || state_reg == ST_ADR || state_reg == ST_WR) begin
        shift_next = {shift_reg[6:0], sda_s2_reg};
        cnt_next   = cnt_reg + 1'b1;
      end else if (state_reg == ST_RD_ACK) begin
        ack_next = ~sda_s2_reg; // see RL12
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_SEL: begin
          if (cnt_reg == BIT_LAST) begin
            state_next = ST_SEL_ACK;
            rw_next    = shift_reg[0];
            oe_next    = (shift_reg[7:4] == SELECT_CODE) && (bcnt_reg == '0); // see RL13
            if (!shift_reg[0]) begin
              hi_next = shift_reg[3:1];
            end
          end
        end
        ST_ADR: begin
          if (cnt_reg == BIT_LAST) begin
            state_next = ST_ADR_ACK;
            oe_next    = 1'b1;
            addr_next  = {hi_reg, shift_reg}; // see RL6
          end
        end
        ST_WR: begin
          if (cnt_reg == BIT_LAST) begin
            state_next = ST_WR_ACK;
            // Only writes look at the inhibit pin
            oe_next    = ~wp_s2_reg; // see RL1
            if (!wp_s2_reg) begin
              mem_we     = 1'b1;
              wrote_next = 1'b1;
              addr_next  = bump(addr_reg, 1'b1);
            end
          end
        end
        ST_SEL_ACK: begin
          oe_next  = 1'b0;
          cnt_next = 4'h0;
          if (!oe_reg) begin
            state_next = ST_IDLE;
          end else if (rw_reg) begin
            load = 1'b1; // see RL4, RL8
          end else begin
            state_next = ST_ADR;
          end
        end
        ST_ADR_ACK, ST_WR_ACK: begin
          oe_next    = 1'b0;
          cnt_next   = 4'h0;
          state_next = ST_WR;
        end
        ST_RD: begin
          if (cnt_reg == 4'h7) begin
            oe_next    = 1'b0;
            state_next = ST_RD_ACK;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = ~shift_reg[6];
            cnt_next   = cnt_reg + 1'b1;
          end
        end
        ST_RD_ACK: begin
          if (ack_reg) begin
            load = 1'b1; // see RL9
          end else begin
            state_next = ST_IDLE; // see RL12
            oe_next    = 1'b0;
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
      if (load) begin
        state_next = ST_RD;
        cnt_next   = 4'h0;
        shift_next = rd_byte;
        oe_next    = ~rd_byte[7];
        addr_next  = bump(addr_reg, 1'b0); // see RL3, RL11, RL14
      end
    end
  end

  // Three stages per line: the first two synchronise, the third gives edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
      wp_s1_reg  <= 1'b0;
      wp_s2_reg  <= 1'b0;
    end else begin
      scl_s1_reg <= link.scl_line;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= link.sda_line;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
      wp_s1_reg  <= write_inhibit_pin;
      wp_s2_reg  <= wp_s1_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg  <= '0;
      hi_reg    <= 3'h0;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      out_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      wrote_reg <= 1'b0;
      bcnt_reg  <= '0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      hi_reg    <= hi_next;
      rw_reg    <= rw_next;
      oe_reg    <= oe_next;
      out_reg   <= 1'b0;
      ack_reg   <= ack_next;
      wrote_reg <= wrote_next;
      bcnt_reg  <= bcnt_next;
      busy_reg  <= bcnt_next != '0;
    end
  end

  // Reset restores the erased image; costly in area but keeps reads defined
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= ERASED; // see RL2
      end
    end else if (mem_we) begin
      mem[addr_reg] <= shift_reg;
    end
  end
endmodule

// ### rtl/eeprom_host_end.sv
`timescale 1ns/1ps
module eeprom_host_end import eeprom_pkg::*; #(
  parameter int unsigned QUARTER     = QUARTER_CYCLES,
  parameter logic [3:0]  SELECT_CODE = SEL_CODE
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  eeprom_link.host               link,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_random,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]        cmd_len,
  output logic                   data_valid,
  input  wire logic              data_ready,
  output logic [7:0]             data_out,
  output logic                   done,
  output logic                   nack_err
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_FRAME = 3'h2,
    H_NEXT  = 3'h3,
    H_PUSH  = 3'h4,
    H_STOP  = 3'h5
  } hstate_type;

  typedef enum logic [1:0] {
    P_SEL_W = 2'h0,
    P_ADDR  = 2'h1,
    P_SEL_R = 2'h2,
    P_DATA  = 2'h3
  } step_type;

  localparam int unsigned QW = $clog2(QUARTER + 1);

  hstate_type        state_reg;
  hstate_type        state_next;
  step_type          step_reg;
  step_type          step_next;
  logic [QW-1:0]     q_reg;
  logic [1:0]        ph_reg;
  logic [1:0]        ph_next;
  logic [8:0]        tx_reg;
  logic [8:0]        tx_next;
  logic [8:0]        rx_reg;
  logic [8:0]        rx_next;
  logic [3:0]        bit_reg;
  logic [3:0]        bit_next;
  logic [7:0]        left_reg;
  logic [7:0]        left_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              scl_oe_reg;
  logic              scl_oe_next;
  logic              sda_oe_reg;
  logic              sda_oe_next;
  logic              ready_reg;
  logic              done_reg;
  logic              done_next;
  logic              err_reg;
  logic              err_next;
  logic              sda_s1_reg;
  logic              sda_s2_reg;
  logic              tick;
  logic              buf_ready;
  logic              push;

  function automatic logic [8:0] select_frame(input logic [ADDR_W-1:0] a, input logic rd);
    return {SELECT_CODE, a[ADDR_W-1:8], rd, 1'b1};
  endfunction

  assign link.m_scl_oe  = scl_oe_reg;
  assign link.m_scl_out = 1'b0;
  assign link.m_sda_oe  = sda_oe_reg;
  assign link.m_sda_out = 1'b0;
  assign cmd_ready      = ready_reg;
  assign done           = done_reg;
  assign nack_err       = err_reg;
  assign tick           = q_reg == '0;
  assign push           = state_reg == H_PUSH;

  byte_skid2 #(
    .W(8)
  ) u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (rx_reg[8:1]),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );

  always_comb begin
    state_next  = state_reg;
    step_next   = step_reg;
    ph_next     = ph_reg;
    tx_next     = tx_reg;
    rx_next     = rx_reg;
    bit_next    = bit_reg;
    left_next   = left_reg;
    addr_next   = addr_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    done_next   = 1'b0;
    err_next    = err_reg;
    unique case (state_reg)
      H_IDLE: begin
        if (cmd_valid) begin
          err_next   = 1'b0;
          addr_next  = cmd_addr;
          left_next  = cmd_len;
          state_next = H_START;
          if (cmd_random) begin
            step_next = P_SEL_W; // see RL6
            tx_next   = select_frame(cmd_addr, 1'b0);
          end else begin
            step_next = P_SEL_R; // see RL4
            tx_next   = select_frame(cmd_addr, 1'b1);
          end
        end
      end
      H_START, H_FRAME, H_STOP: begin
        if (tick) begin
          ph_next = ph_reg + 1'b1;
          if (ph_reg == 2'h0) begin
            scl_oe_next = 1'b1;
          end else if (ph_reg == 2'h2) begin
            scl_oe_next = 1'b0;
          end
          if (state_reg == H_START) begin
            if (ph_reg == 2'h1) begin
              sda_oe_next = 1'b0;
            end else if (ph_reg == 2'h3) begin
              sda_oe_next = 1'b1;
              bit_next    = 4'h0;
              state_next  = H_FRAME;
            end
          end else if (state_reg == H_STOP) begin
            if (ph_reg == 2'h1) begin
              sda_oe_next = 1'b1;
            end else if (ph_reg == 2'h3) begin
              sda_oe_next = 1'b0; // see RL5, RL10
              done_next   = 1'b1;
              state_next  = H_IDLE;
            end
          end else begin
            if (ph_reg == 2'h0) begin
              // Let go with the clock fall when the slot is not ours, so the
              // device never finds the line still held when it starts to drive
              if (tx_reg[8]) begin
                sda_oe_next = 1'b0;
              end
            end else if (ph_reg == 2'h1) begin
              sda_oe_next = ~tx_reg[8];
            end else if (ph_reg == 2'h3) begin
              rx_next  = {rx_reg[7:0], sda_s2_reg};
              tx_next  = {tx_reg[7:0], 1'b1};
              bit_next = bit_reg + 1'b1;
              if (bit_reg == BIT_LAST) begin
                state_next = H_NEXT;
              end
            end
          end
        end
      end
      H_NEXT: begin
        if (step_reg == P_DATA) begin
          state_next = H_PUSH;
        end else if (rx_reg[0]) begin
          err_next   = 1'b1;
          state_next = H_STOP;
        end else if (step_reg == P_SEL_W) begin
          step_next  = P_ADDR;
          tx_next    = {addr_reg[7:0], 1'b1};
          bit_next   = 4'h0;
          state_next = H_FRAME;
        end else if (step_reg == P_ADDR) begin
          // Same upper select bits as the dummy write
          step_next  = P_SEL_R;
          tx_next    = select_frame(addr_reg, 1'b1); // see RL7
          state_next = H_START;
        end else begin
          step_next  = P_DATA;
          tx_next    = {8'hFF, left_reg == 8'h00};
          bit_next   = 4'h0;
          state_next = H_FRAME;
        end
      end
      H_PUSH: begin
        // The bus waits with SCL high while the buffer is full, so no byte is lost
        if (buf_ready) begin
          if (left_reg == 8'h00) begin
            state_next = H_STOP;
          end else begin
            left_next  = left_reg - 1'b1;
            tx_next    = {8'hFF, left_reg == 8'h01}; // see RL10
            bit_next   = 4'h0;
            state_next = H_FRAME;
          end
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      q_reg      <= '0;
    end else begin
      sda_s1_reg <= link.sda_line;
      sda_s2_reg <= sda_s1_reg;
      q_reg      <= tick ? QW'(QUARTER - 1) : q_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= H_IDLE;
      step_reg   <= P_SEL_R;
      ph_reg     <= 2'h0;
      tx_reg     <= 9'h1FF;
      rx_reg     <= 9'h000;
      bit_reg    <= 4'h0;
      left_reg   <= 8'h00;
      addr_reg   <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ready_reg  <= 1'b0;
      done_reg   <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      step_reg   <= step_next;
      ph_reg     <= ph_next;
      tx_reg     <= tx_next;
      rx_reg     <= rx_next;
      bit_reg    <= bit_next;
      left_reg   <= left_next;
      addr_reg   <= addr_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      ready_reg  <= state_next == H_IDLE;
      done_reg   <= done_next;
      err_reg    <= err_next;
    end
  end
endmodule

// ### tb/eeprom_link_props.sv
`timescale 1ns/1ps
module eeprom_link_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence start_seen;
    scl_line && $fell(sda_line);
  endsequence

  sequence scl_fall;
    $fell(scl_line);
  endsequence

  // Open drain: a driver may only pull low
  open_drain_a: assert property (!m_scl_out && !m_sda_out && !s_sda_out)
    else $error("open drain output driven high");
  start_hold_a: assert property (start_seen |-> scl_line [*3])
    else $error("clock fell too soon after start");
  scl_low_min_a: assert property (scl_fall |-> !scl_line [*7])
    else $error("clock low phase too short");
  scl_high_min_a: assert property ($rose(scl_line) |-> scl_line [*7])
    else $error("clock high phase too short");
  no_contention_a: assert property (!(s_sda_oe && m_sda_oe))
    else $error("both ends pull data at once");
  dev_low_change_a: assert property ($changed(s_sda_oe) |-> !scl_line)
    else $error("device changed data while clock high");
  host_frames_a: assert property (scl_line && $past(scl_line) && $changed(sda_line) |->
    !s_sda_oe && !$past(s_sda_oe))
    else $error("device made a start or stop");
  dev_release_a: assert property ($rose(s_sda_oe) |-> ##[1:40] !s_sda_oe)
    else $error("device held data low too long");
endmodule

// ### tb/test_serial_eeprom_read_path.sv
`timescale 1ns/1ps
module test_serial_eeprom_read_path;
  import eeprom_pkg::*;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              cmd_ready;
  logic              cmd_random = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = 11'h000;
  logic [7:0]        cmd_len = 8'h00;
  logic              data_valid;
  logic              data_ready = 1'b1;
  logic [7:0]        data_out;
  logic              done;
  logic              nack_err;
  logic              busy;
  logic              write_inhibit_pin = 1'b0;
  logic [ADDR_W-1:0] byte_addr;
  logic [ADDR_W-1:0] exp_addr = 11'h000;
  logic [31:0]       seed = 32'h0000004C;
  int                err_count = 0;
  int                tests_run = 0;
  bit                hung = 1'b0;

  always #4 mclk = ~mclk;

  eeprom_link eeprom_link_inst ();

  eeprom_read_end #(.WRITE_CYCLES(20)) eeprom_read_end_inst (
    .mclk(mclk), .nrst(nrst), .link(eeprom_link_inst),
    .write_inhibit_pin(write_inhibit_pin), .busy(busy), .byte_addr(byte_addr));

  // Short quarter keeps the run brief; 4 is the floor for the seven-cycle clock phase checks
  eeprom_host_end #(.QUARTER(4)) eeprom_host_end_inst (
    .mclk(mclk), .nrst(nrst), .link(eeprom_link_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_random(cmd_random), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .data_valid(data_valid), .data_ready(data_ready), .data_out(data_out), .done(done),
    .nack_err(nack_err));

  eeprom_link_props eeprom_link_props_inst (
    .mclk(mclk), .nrst(nrst), .scl_line(eeprom_link_inst.scl_line),
    .sda_line(eeprom_link_inst.sda_line), .m_scl_out(eeprom_link_inst.m_scl_out),
    .m_scl_oe(eeprom_link_inst.m_scl_oe), .m_sda_out(eeprom_link_inst.m_sda_out),
    .m_sda_oe(eeprom_link_inst.m_sda_oe), .s_sda_out(eeprom_link_inst.s_sda_out),
    .s_sda_oe(eeprom_link_inst.s_sda_oe));

  function automatic logic [31:0] xs_next(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // Eleven-bit sum wraps from the top address to zero by itself
  function automatic logic [ADDR_W-1:0] addr_after(input logic [ADDR_W-1:0] a, input logic [7:0] len);
    return a + {3'h0, len} + 11'h001;
  endfunction

  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_addr(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns just after one
  task automatic run_cmd(input logic rnd, input logic [ADDR_W-1:0] a, input logic [7:0] len);
    int n;
    int k;
    bit seen_done;
    n = 0;
    k = 0;
    seen_done = 1'b0;
    // After a hang the remaining commands are skipped and the verdict follows
    if (hung) begin
      return;
    end
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 100) begin
      err_count++;
      $display("wrong value cmd_ready expected 1 seen timeout");
      hung = 1'b1;
      return;
    end
    cmd_valid <= 1'b1;
    cmd_random <= rnd;
    cmd_addr <= a;
    cmd_len <= len;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    k = 0;
    while (k < 30000) begin
      @(posedge mclk);
      if (data_valid === 1'b1 && data_ready === 1'b1) begin
        check_byte("data_out", ERASED, data_out);
        n++;
      end
      if (done === 1'b1) begin
        seen_done = 1'b1;
      end
      if (seen_done && data_valid !== 1'b1) begin
        break;
      end
      // Random stalls drop data_ready about one cycle in four; inhibit level must not matter to reads
      seed = xs_next(seed);
      data_ready <= seed[0] | seed[1];
      write_inhibit_pin <= seed[2];
      k++;
    end
    if (k >= 30000) begin
      err_count++;
      $display("wrong value done expected 1 seen timeout");
      hung = 1'b1;
      return;
    end
    exp_addr = rnd ? addr_after(a, len) : addr_after(exp_addr, len);
    check_count("bytes read", int'(len) + 1, n);
    check_addr("byte_addr", exp_addr, byte_addr);
    check_flag("nack_err", 1'b0, nack_err);
    check_flag("busy", 1'b0, busy);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    run_cmd(1'b1, 11'h7FE, 8'h03);
    check_addr("wrap address", 11'h002, byte_addr);
    run_cmd(1'b0, 11'h000, 8'h00);
    run_cmd(1'b0, 11'h000, 8'h05);
    run_cmd(1'b1, 11'h000, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = xs_next(seed);
      run_cmd(seed[31], seed[10:0], {4'h0, seed[15:12]});
    end
    print_verdict();
  end
endmodule
